// ### include/pds_pkg.sv
// package for the power-down and sample-timing setup block: register map,
// field positions, reset values and the packed carriers shared by the files.
// assumes a 32-bit APB3 slave port and a single 40 MHz master clock.
package pds_pkg;

   // register indices as printed; the byte address is four times the index
   localparam logic [7:0] PDS_IDX_POWER = 8'h07; // power_down_controls
   localparam logic [7:0] PDS_IDX_TIMING = 8'h08; // sample_timing_and_clamp_setup
   localparam logic [7:0] PDS_IDX_MODE = 8'h09; // mode bits kept outside the two setup words
   localparam logic [7:0] PDS_IDX_STATUS = 8'h0A; // read-only pin and switch state

   localparam int PDS_ADDR_W = 8; // APB address bits decoded
   localparam int PDS_DATA_W = 32; // APB data width
   localparam int PDS_REG_W = 8; // width of every register
   localparam int PDS_DELAY_W = 3; // width of the pulse delay field
   localparam int PDS_DELAY_MAX = 7; // longest pulse delay in clock periods

   // power_down_controls fields
   localparam int PDS_PD_RED = 0;
   localparam int PDS_PD_GREEN = 1;
   localparam int PDS_PD_BLUE = 2;
   localparam int PDS_PD_CONV = 3;
   localparam int PDS_PD_DAC = 4;
   localparam int PDS_PD_REFBUF = 5;
   localparam int PDS_PD_AUXBUF = 6;
   localparam logic [7:0] PDS_POWER_RESET = 8'h00;
   localparam logic [7:0] PDS_POWER_MASK = 8'h7F; // bit 7 reserved, reads zero

   // sample_timing_and_clamp_setup fields
   localparam int PDS_TM_DETECT = 0;
   localparam int PDS_TM_DELAY_LO = 1; // delay field is bits 3:1
   localparam int PDS_TM_POLARITY = 4;
   localparam int PDS_TM_CLAMP_EN = 5;
   localparam int PDS_TM_SWITCH_CTRL = 6;
   localparam logic [7:0] PDS_TIMING_RESET = 8'h20; // clamp_enable resets to one
   localparam logic [7:0] PDS_TIMING_MASK = 8'h7F;

   // mode register fields
   localparam int PDS_MD_NIBBLE = 0;
   localparam int PDS_MD_AUTO_CYCLE = 1;
   localparam int PDS_MD_MANUAL_CLAMP = 2;
   localparam int PDS_MD_REF_SEL_LO = 3; // sampling_reference_select is bits 4:3
   localparam logic [7:0] PDS_MODE_RESET = 8'h00;
   localparam logic [7:0] PDS_MODE_MASK = 8'h1F;

   // status register fields
   localparam int PDS_ST_VIDEO = 0;
   localparam int PDS_ST_RESET = 1;
   localparam int PDS_ST_SWITCH = 2;
   localparam int PDS_ST_TIMING = 3;

   // power-down strobes driven to the analogue stages
   typedef struct packed {
      logic aux_reference_buffer_disable;
      logic converter_reference_buffer_disable;
      logic clamp_dac_powerdown;
      logic converter_powerdown;
      logic blue_stage_powerdown;
      logic green_stage_powerdown;
      logic red_stage_powerdown;
   } pds_power_t;

   // APB answer group
   typedef struct packed {
      logic pready;
      logic pslverr;
      logic [31:0] prdata;
   } pds_apb_rsp_t;

endpackage

// ### logic/pds_edge_delay.sv
// edge detector with a programmable delay line for one filtered pin level.
// assumes the level input is already synchronised to clk.
`timescale 1ns/1ps
module pds_edge_delay (
   input wire logic clk,
   input wire logic rst,
   input wire logic level, // filtered pin level
   input wire logic enable, // detector armed
   input wire logic rising, // 1 = rising edges, 0 = falling edges
   input wire logic [2:0] delay, // clock periods between edge and pulse
   output logic pulse // one clock wide
);
   logic level_prev_reg; // level one cycle ago
   logic [pds_pkg::PDS_DELAY_MAX-1:0] line_reg; // delay line, stage n is n+1 cycles late
   logic edge_seen; // selected edge in this cycle

   // one edge per change of the filtered level, so a pulse is always one cycle wide
   always_comb begin
      if (rising) begin
         edge_seen = enable & level & ~level_prev_reg;
      end else begin
         edge_seen = enable & ~level & level_prev_reg;
      end
   end

   // previous level tracker
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         level_prev_reg <= 1'b0;
      end else begin
         level_prev_reg <= level;
      end
   end

   // shift the edge down the line; an unarmed detector flushes it
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         line_reg <= '0;
      end else if (!enable) begin
         line_reg <= '0;
      end else begin
         line_reg <= {line_reg[pds_pkg::PDS_DELAY_MAX-2:0], edge_seen};
      end
   end

   // tap selection; zero delay takes the edge itself
   always_comb begin
      if (delay == 3'h0) begin
         pulse = edge_seen;
      end else begin
         pulse = line_reg[delay - 3'h1];
      end
   end
endmodule

// ### logic/pds_setup_top.sv
// setup register bank for power-down and sample-timing control, with the
// sample edge detector and the clamp switch steering.
// assumes an APB3 master on clk and pins that come straight from the board.
`timescale 1ns/1ps
module pds_setup_top (
   input wire logic clk,
   input wire logic rst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic video_sample_pin,
   input wire logic reset_sample_pin,
   output pds_pkg::pds_power_t power_down,
   output logic clamp_dac_drive_en,
   output logic timing_sample,
   output logic clamp_switch_closed
);
   // no wait states and no interrupt of its own; every pin-facing output
   // leaves a flop so the analogue side never sees decode glitches
   // byte address of a register index; registers sit on aligned 32-bit
   // words, so the index is shifted past the two byte-lane bits
   function automatic logic [7:0] byte_addr(input logic [7:0] idx);
      byte_addr = {idx[5:0], 2'b00};
   endfunction

   // does an address hit a register index; the compare is exact, so an
   // address inside a word but off its first byte counts as unmapped
   function automatic logic hits(input logic [7:0] addr, input logic [7:0] idx);
      hits = (addr == byte_addr(idx));
   endfunction

   // software-visible state; reserved bits are stored as zero, so a read
   // returns exactly what the hardware acts on
   logic [7:0] power_reg; // power_down_controls
   logic [7:0] timing_reg; // sample_timing_and_clamp_setup
   logic [7:0] mode_reg; // nibble mode, auto cycle, manual clamp, reference select

   // apb answer flops; pready, pslverr and prdata travel in one struct,
   // so they can never disagree by a cycle
   pds_pkg::pds_apb_rsp_t rsp_reg;
   pds_pkg::pds_apb_rsp_t rsp_next;

   // pin synchronisers, three flops each; stage zero may go metastable
   // and is read by nothing but stage one
   logic [2:0] video_sync_reg;
   logic [2:0] reset_sync_reg;
   logic video_level_reg; // filtered video-sample level
   logic reset_level_reg; // filtered reset-sample level

   // derived controls, named after the register fields so that the steering
   // below reads like the field list rather than like bit positions
   logic nibble_output_mode;
   logic auto_cycle_enable;
   logic clamp_manual_enable;
   logic [1:0] sampling_reference_select;
   logic sample_edge_detect_enable;
   logic [2:0] sample_pulse_delay;
   logic sample_edge_polarity;
   logic clamp_enable;
   logic clamp_switch_control;
   logic detect_armed; // both nibble mode and detect enabled
   logic detect_pulse; // delayed internal pulse
   logic clamp_pulse; // per-pixel clamp moment in nibble mode
   logic timing_next;
   logic switch_next;
   logic setup_phase; // first cycle of an apb transfer
   logic write_commit; // access edge of a write
   logic mapped; // address decodes to a register

   // field extraction
   always_comb begin
      nibble_output_mode = mode_reg[pds_pkg::PDS_MD_NIBBLE];
      auto_cycle_enable = mode_reg[pds_pkg::PDS_MD_AUTO_CYCLE];
      clamp_manual_enable = mode_reg[pds_pkg::PDS_MD_MANUAL_CLAMP];
      sampling_reference_select = mode_reg[pds_pkg::PDS_MD_REF_SEL_LO +: 2];
      sample_edge_detect_enable = timing_reg[pds_pkg::PDS_TM_DETECT];
      sample_pulse_delay = timing_reg[pds_pkg::PDS_TM_DELAY_LO +: pds_pkg::PDS_DELAY_W];
      sample_edge_polarity = timing_reg[pds_pkg::PDS_TM_POLARITY];
      clamp_enable = timing_reg[pds_pkg::PDS_TM_CLAMP_EN];
      clamp_switch_control = timing_reg[pds_pkg::PDS_TM_SWITCH_CTRL];
   end

   // detector only runs when nibble mode and detect enable are both set
   // delay and polarity are don't-care while it is off
   assign detect_armed = nibble_output_mode & sample_edge_detect_enable;

   // --------------------------------------------------------------------
   // apb slave: zero wait states, answer prepared in the setup cycle so
   // that prdata, pready and pslverr all leave flops
   // --------------------------------------------------------------------
   assign setup_phase = psel & ~penable;
   assign write_commit = psel & penable & pwrite & rsp_reg.pready;
   assign mapped = hits(paddr, pds_pkg::PDS_IDX_POWER) | hits(paddr, pds_pkg::PDS_IDX_TIMING)
                   | hits(paddr, pds_pkg::PDS_IDX_MODE) | hits(paddr, pds_pkg::PDS_IDX_STATUS);

   // read mux and answer
   always_comb begin
      rsp_next = '0;
      if (setup_phase) begin
         rsp_next.pready = 1'b1;
         rsp_next.pslverr = ~mapped; // unmapped address errors, read data zero
         if (!pwrite) begin
            if (hits(paddr, pds_pkg::PDS_IDX_POWER)) begin
               rsp_next.prdata[7:0] = power_reg;
            end else if (hits(paddr, pds_pkg::PDS_IDX_TIMING)) begin
               rsp_next.prdata[7:0] = timing_reg;
            end else if (hits(paddr, pds_pkg::PDS_IDX_MODE)) begin
               rsp_next.prdata[7:0] = mode_reg;
            end else if (hits(paddr, pds_pkg::PDS_IDX_STATUS)) begin
               // read-only snapshot of the filtered pins and the two outputs;
               // a write here is accepted without error and dropped
               rsp_next.prdata[pds_pkg::PDS_ST_VIDEO] = video_level_reg;
               rsp_next.prdata[pds_pkg::PDS_ST_RESET] = reset_level_reg;
               rsp_next.prdata[pds_pkg::PDS_ST_SWITCH] = clamp_switch_closed;
               rsp_next.prdata[pds_pkg::PDS_ST_TIMING] = timing_sample;
            end else begin
               rsp_next.prdata = '0;
            end
         end
      end
   end

   // answer flops; cleared in every cycle that is not a setup cycle, so pready
   // is a one-cycle pulse and a stalled access phase gets no second answer
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         rsp_reg <= '0;
      end else begin
         rsp_reg <= rsp_next;
      end
   end

   assign prdata = rsp_reg.prdata;
   assign pready = rsp_reg.pready;
   assign pslverr = rsp_reg.pslverr;

   // power-down register; the reserved bit is dropped so it always reads zero
   // a write lands at the access edge, the one at which pready is high
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         power_reg <= pds_pkg::PDS_POWER_RESET;
      end else if (write_commit && hits(paddr, pds_pkg::PDS_IDX_POWER)) begin
         power_reg <= pwdata[7:0] & pds_pkg::PDS_POWER_MASK;
      end
   end

   // timing and clamp setup register
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         timing_reg <= pds_pkg::PDS_TIMING_RESET;
      end else if (write_commit && hits(paddr, pds_pkg::PDS_IDX_TIMING)) begin
         timing_reg <= pwdata[7:0] & pds_pkg::PDS_TIMING_MASK;
      end
   end

   // mode register: nibble output, auto-cycle, manual clamp and reference
   // select, kept apart because the two setup words have only bit 7 spare
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         mode_reg <= pds_pkg::PDS_MODE_RESET;
      end else if (write_commit && hits(paddr, pds_pkg::PDS_IDX_MODE)) begin
         mode_reg <= pwdata[7:0] & pds_pkg::PDS_MODE_MASK;
      end
   end

   // --------------------------------------------------------------------
   // power-down strobes; registered so the analogue side sees clean levels
   // --------------------------------------------------------------------
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         power_down <= '0;
         clamp_dac_drive_en <= 1'b1;
      end else begin
         power_down.red_stage_powerdown <= power_reg[pds_pkg::PDS_PD_RED];
         power_down.green_stage_powerdown <= power_reg[pds_pkg::PDS_PD_GREEN];
         power_down.blue_stage_powerdown <= power_reg[pds_pkg::PDS_PD_BLUE];
         // converter alone; the reference buffers have their own bit
         power_down.converter_powerdown <= power_reg[pds_pkg::PDS_PD_CONV];
         power_down.clamp_dac_powerdown <= power_reg[pds_pkg::PDS_PD_DAC];
         power_down.converter_reference_buffer_disable <=
            power_reg[pds_pkg::PDS_PD_REFBUF];
         power_down.aux_reference_buffer_disable <= power_reg[pds_pkg::PDS_PD_AUXBUF];
         // a powered-down DAC releases the clamp level pin to an outside source
         clamp_dac_drive_en <= ~power_reg[pds_pkg::PDS_PD_DAC];
      end
   end

   // --------------------------------------------------------------------
   // pin synchronisers: a change counts once stages one and two agree,
   // which costs three cycles of latency but rejects a one-cycle glitch
   // --------------------------------------------------------------------
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         video_sync_reg <= '0;
         reset_sync_reg <= '0;
      end else begin
         video_sync_reg <= {video_sync_reg[1:0], video_sample_pin};
         reset_sync_reg <= {reset_sync_reg[1:0], reset_sample_pin};
      end
   end

   // filtered levels; hold the old value while stages one and two differ
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         video_level_reg <= 1'b0;
         reset_level_reg <= 1'b0;
      end else begin
         if (video_sync_reg[1] == video_sync_reg[2]) begin
            video_level_reg <= video_sync_reg[2];
         end
         if (reset_sync_reg[1] == reset_sync_reg[2]) begin
            reset_level_reg <= reset_sync_reg[2];
         end
      end
   end

   // sample edge detector with programmable delay; its line is flushed when
   // disarmed, so no stale pulse leaks out after a mode change
   pds_edge_delay u_detect (
      .clk(clk),
      .rst(rst),
      .level(video_level_reg),
      .enable(detect_armed),
      .rising(sample_edge_polarity),
      .delay(sample_pulse_delay),
      .pulse(detect_pulse)
   );

   // per-pixel clamp moment in nibble mode: the sample timing pulse's rising
   // edge delayed by the reference select field
   pds_edge_delay u_clamp_time (
      .clk(clk),
      .rst(rst),
      .level(timing_sample),
      .enable(nibble_output_mode),
      .rising(1'b1),
      .delay({1'b0, sampling_reference_select}),
      .pulse(clamp_pulse)
   );

   // timing control source selection; a disarmed detector hands back the
   // filtered level from the next edge on
   always_comb begin
      if (detect_armed) begin
         timing_next = detect_pulse;
      end else begin
         timing_next = video_level_reg;
      end
   end

   // clamp switch steering, highest priority first
   // clamp_enable low wins over every mode: the switch then stays open
   always_comb begin
      if (!clamp_enable) begin
         switch_next = 1'b0;
      end else if (auto_cycle_enable) begin
         // reset-sample pin is busy cycling channels
         switch_next = clamp_manual_enable;
      end else if (nibble_output_mode) begin
         // control bit is not looked at here
         switch_next = clamp_pulse;
      end else if (!clamp_switch_control) begin
         // control bit low: the reset-sample level drives the switch
         switch_next = reset_level_reg;
      end else begin
         // control bit high: both sample levels must be high at once
         switch_next = reset_level_reg & video_level_reg;
      end
   end

   // registered pin-facing outputs
   // both come from flops, costing one cycle against the filtered pins
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         timing_sample <= 1'b0;
         clamp_switch_closed <= 1'b0;
      end else begin
         timing_sample <= timing_next;
         clamp_switch_closed <= switch_next;
      end
   end
endmodule

// ### sim/pds_timing_ctrl.sv
// far-side model: scanner timing controller driving both sample pins.
// assumes the bench requests pin levels; pins move one clock later.
`timescale 1ns/1ps
module pds_timing_ctrl (
   input wire logic clk,
   input wire logic rst,
   input wire logic video_want,
   input wire logic reset_want,
   output logic video_sample_pin,
   output logic reset_sample_pin
);
   // registered like a real controller, so edges land just after clk
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         video_sample_pin <= 1'b0;
         reset_sample_pin <= 1'b0;
      end else begin
         video_sample_pin <= video_want;
         reset_sample_pin <= reset_want;
      end
   end
endmodule

// ### sim/pds_setup_properties.sv
// checker for the setup block, fed only from the top-level ports.
// assumes byte addresses 0x1C/0x20/0x24 and writes committing with pready.
`timescale 1ns/1ps
module pds_setup_properties (
   input wire logic clk,
   input wire logic rst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic video_sample_pin,
   input wire logic reset_sample_pin,
   input wire pds_pkg::pds_power_t power_down,
   input wire logic clamp_dac_drive_en,
   input wire logic timing_sample,
   input wire logic clamp_switch_closed
);
   logic [7:0] pwr_sh; // shadow of power_down_controls
   logic [7:0] tim_sh; // shadow of the timing setup word
   logic [7:0] mode_sh; // shadow of the mode word
   wire wr_ok = psel && penable && pready && pwrite; // committing write
   wire armed = mode_sh[0] && tim_sh[0]; // detector really live
   wire plain = (mode_sh[1:0] == 2'b00) && tim_sh[5]; // pin-steered clamp
   // shadows track committed writes; reserved bits never stick
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         pwr_sh <= 8'h00;
         tim_sh <= 8'h20;
         mode_sh <= 8'h00;
      end else if (wr_ok) begin
         case (paddr)
            8'h1C: pwr_sh <= pwdata[7:0] & 8'h7F;
            8'h20: tim_sh <= pwdata[7:0] & 8'h7F;
            8'h24: mode_sh <= pwdata[7:0] & 8'h1F;
            default: ;
         endcase
      end
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   // eight quiet armed cycles: long enough to outlast the longest delay
   sequence s_quiet; (armed && $stable(video_sample_pin))[*8]; endsequence
   sequence s_auto; ($stable(mode_sh) && $stable(tim_sh) && mode_sh[1] && tim_sh[5])[*3]; endsequence
   property p_power; power_down == $past(pwr_sh[6:0]); endproperty
   a_power: assert property (p_power) else $error("power-down level mismatch");
   property p_dac; clamp_dac_drive_en == !$past(pwr_sh[4]); endproperty
   a_dac: assert property (p_dac) else $error("clamp dac drive mismatch");
   property p_nocl; (!tim_sh[5])[*3] |-> !clamp_switch_closed; endproperty
   a_nocl: assert property (p_nocl) else $error("switch closed while clamp off");
   property p_follow; (plain && !tim_sh[6] && $stable(reset_sample_pin))[*8]
      |-> clamp_switch_closed == reset_sample_pin; endproperty
   a_follow: assert property (p_follow) else $error("switch not following reset pin");
   property p_both; (plain && tim_sh[6] && $stable({reset_sample_pin, video_sample_pin}))[*8]
      |-> clamp_switch_closed == (reset_sample_pin && video_sample_pin); endproperty
   a_both: assert property (p_both) else $error("switch not the and of pins");
   property p_manual; s_auto |-> clamp_switch_closed == mode_sh[2]; endproperty
   a_manual: assert property (p_manual) else $error("manual clamp bit ignored");
   property p_pass; (!armed && $stable(video_sample_pin))[*8]
      |-> timing_sample == video_sample_pin; endproperty
   a_pass: assert property (p_pass) else $error("video level not passed through");
   property p_pulse; armed[*2] ##1 (armed && timing_sample) |=> !timing_sample; endproperty
   a_pulse: assert property (p_pulse) else $error("timing pulse wider than one");
   property p_quiet; s_quiet ##1 s_quiet |-> !timing_sample; endproperty
   a_quiet: assert property (p_quiet) else $error("pulse without a pin edge");
endmodule

bind pds_setup_top pds_setup_properties u_chk (.clk(clk), .rst(rst), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
   .pready(pready), .pslverr(pslverr), .video_sample_pin(video_sample_pin),
   .reset_sample_pin(reset_sample_pin), .power_down(power_down),
   .clamp_dac_drive_en(clamp_dac_drive_en), .timing_sample(timing_sample),
   .clamp_switch_closed(clamp_switch_closed));

// ### sim/testbench.sv
// self-checking bench: APB tasks, read scoreboard, clamp table, edge sweep.
// assumes one-cycle APB answers and the pin model one clock behind requests.
`timescale 1ns/1ps
module testbench;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic pready, pslverr, vs_pin, rs_pin, ts, sw, dac_en;
   logic vw = 1'b0; // requested video pin level
   logic rw = 1'b0; // requested reset pin level
   pds_pkg::pds_power_t pd;
   logic [32:0] exp_q[$]; // oldest expected {pslverr, prdata} first
   int error_cnt = 0;
   int checked = 0;
   // {timing word, mode word, reset pin, video pin, expected switch}
   logic [18:0] tbl [8] = '{{8'h20, 8'h00, 3'b101}, {8'h20, 8'h00, 3'b010},
      {8'h60, 8'h00, 3'b100}, {8'h60, 8'h00, 3'b111}, {8'h5F, 8'h00, 3'b110},
      {8'h60, 8'h01, 3'b110}, {8'h20, 8'h06, 3'b001}, {8'h20, 8'h02, 3'b110}};
   always #12.5 clk = ~clk;
   pds_timing_ctrl u_far (.clk(clk), .rst(rst), .video_want(vw), .reset_want(rw),
      .video_sample_pin(vs_pin), .reset_sample_pin(rs_pin));
   pds_setup_top DUT (.clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .video_sample_pin(vs_pin), .reset_sample_pin(rs_pin), .power_down(pd),
      .clamp_dac_drive_en(dac_en), .timing_sample(ts), .clamp_switch_closed(sw));
   task chk(input string nm, input logic [32:0] got, input logic [32:0] exp);
      checked++;
      if (got !== exp) begin
         error_cnt++;
         $display("wrong value %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task conclude;
      $display("errors %0d checks %0d", error_cnt, checked);
      if (error_cnt == 0 && checked > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   task wt(input int n);
      repeat (n) @(posedge clk);
   endtask
   // one APB transfer; an idle edge follows so psel is never set twice at once
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (n >= 20) begin
         chk("pready_wait", 33'h0, 33'h1);
         conclude();
      end
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask
   task wr(input logic [7:0] a, input logic [7:0] d);
      apb(1'b1, a, {24'h0, d});
   endtask
   task rd(input logic [7:0] a, input logic [32:0] e);
      exp_q.push_back(e);
      apb(1'b0, a, 32'h0);
   endtask
   // counts timing pulses and switch-closed cycles, notes first pulse time
   task pulses(input int len, output int n, output int s, output int lat);
      n = 0;
      s = 0;
      lat = 0;
      for (int i = 1; i <= len; i++) begin
         @(posedge clk);
         if (ts === 1'b1 && lat == 0) lat = i;
         if (ts === 1'b1) n++;
         if (sw === 1'b1) s++;
      end
   endtask
   // scoreboard: each completed read meets the oldest note
   always @(posedge clk) begin
      if (psel && penable && pready === 1'b1 && !pwrite) begin
         if (exp_q.size() == 0) chk("read_unexpected", 33'h0, 33'h1);
         else chk("read", {pslverr, prdata}, exp_q.pop_front());
      end
   end
   initial begin
      int n, s, lat, l0;
      logic [7:0] v;
      void'($urandom(32'h82f95c59));
      wt(16);
      rst <= 1'b0;
      wt(1);
      chk("pd_reset", 33'(pd), 33'h0);
      chk("dac_reset", 33'(dac_en), 33'h1);
      rd(8'h1C, 33'h0);
      rd(8'h20, 33'h20);
      rd(8'h24, 33'h0);
      rd(8'h40, 33'h100000000);
      // walking ones, then random words; bit 7 always written zero
      for (int i = 0; i < 10; i++) begin
         v = (i < 7) ? 8'h01 << i : 8'($urandom) & 8'h7F;
         wr(8'h1C, v);
         rd(8'h1C, 33'(v));
         chk("power", 33'(pd), 33'(v[6:0]));
         chk("dac_en", 33'(dac_en), 33'(!v[4]));
      end
      for (int i = 0; i < 8; i++) begin
         wr(8'h24, tbl[i][10:3]);
         wr(8'h20, tbl[i][18:11]);
         rd(8'h20, 33'(tbl[i][18:11]));
         rw <= tbl[i][2];
         vw <= tbl[i][1];
         wt(12);
         chk("switch", 33'(sw), 33'(tbl[i][0]));
         chk("timing", 33'(ts), 33'(tbl[i][1]));
         rd(8'h28, 33'({tbl[i][1], tbl[i][0], tbl[i][2], tbl[i][1]}));
      end
      // nibble mode: one clamp close per pixel, three cycles after each rise
      wr(8'h24, 8'h19);
      wr(8'h20, 8'h20);
      rd(8'h24, 33'h19);
      rw <= 1'b0;
      vw <= 1'b0;
      wt(12);
      l0 = 0;
      repeat (4) begin
         vw <= 1'b1;
         pulses(8, n, s, lat);
         l0 += s;
         vw <= 1'b0;
         pulses(8, n, s, lat);
         l0 += s;
      end
      chk("clamp_pulses", 33'(l0), 33'h4);
      // detector sweep over both polarities and every delay
      for (int p = 0; p < 2; p++) begin
         for (int d = 0; d < 8; d++) begin
            wr(8'h20, 8'h21 | 8'(d << 1) | 8'(p << 4));
            vw <= (p == 0);
            wt(20);
            vw <= (p == 1);
            pulses(30, n, s, lat);
            chk("pulse_count", 33'(n), 33'h1);
            if (p == 0 && d == 0) l0 = lat; // both polarities share one base
            chk("pulse_delay", 33'(lat), 33'(l0 + d));
            vw <= (p == 0);
            pulses(30, n, s, lat);
            chk("wrong_edge", 33'(n), 33'h0);
         end
      end
      chk("pending", 33'(exp_q.size()), 33'h0);
      conclude();
   end
endmodule
